/* File: spc_checker.sv */
// segment register privilege checker with an axi4-lite status port
`timescale 1ns/1ps
`default_nettype none

module spc_checker
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // mode of the executing code
    input wire logic long_mode,
    input wire logic code64,
    // control transfer into a code segment of another level
    input wire logic xfer_valid,
    input wire logic [1:0] xfer_level,
    // segment load request
    input wire logic req_valid,
    input wire logic [2:0] req_target,
    input wire logic [15:0] req_selector,
    input wire logic [63:0] req_descriptor,
    input wire logic req_limit_viol,
    input wire logic req_type_viol,
    input wire logic req_sys_table,
    // load answer
    output logic load_done,
    output logic protection_fault,
    output logic [4:0][15:0] seg_sel,
    output logic [4:0][63:0] seg_desc,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // true for the four data segment registers
    function automatic logic is_data_tgt(input logic [2:0] t);
        is_data_tgt = (t == TGT_DATA_PRIMARY) || (t == TGT_DATA_EXTRA) ||
                      (t == TGT_DATA_THIRD) || (t == TGT_DATA_FOURTH);
    endfunction : is_data_tgt

    // true for a mapped register offset
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_STATUS) ||
                    (a == REG_FAULT_CNT) || (a == REG_LAST_SEL);
    endfunction : is_mapped

    logic [1:0] current_priv_level;
    spc_result_t result;
    logic [2:0] last_tgt;
    logic [2:0] fault_tgt;
    logic [15:0] last_sel;
    logic [31:0] ctrl;
    logic [31:0] fault_cnt;

    // level extraction from selector and descriptor
    wire logic [1:0] requestor_priv_level = req_selector[SEL_LVL_LSB +: LVL_W];
    wire logic [1:0] descriptor_priv_level = req_descriptor[DESC_LVL_LSB +: LVL_W];

    // effective level is the numerically larger one
    wire logic [1:0] eff_level = (requestor_priv_level > current_priv_level) ?
                                 requestor_priv_level : current_priv_level;

    // mode relaxations
    wire logic mode64 = long_mode && code64;
    wire logic limit_fail = req_limit_viol && !(mode64 && !req_sys_table);
    wire logic type_fail = req_type_viol && !mode64;

    // privilege decision per target class
    wire logic tgt_data = is_data_tgt(req_target);
    wire logic tgt_stack = (req_target == TGT_STACK);
    wire logic data_ok = (eff_level <= descriptor_priv_level);
    wire logic stack_req_ok = (requestor_priv_level == current_priv_level);
    wire logic stack_desc_ok = (descriptor_priv_level == current_priv_level);
    wire logic priv_ok = tgt_data ? data_ok : (stack_req_ok && stack_desc_ok);
    wire logic req_legal = tgt_data || tgt_stack;
    wire logic load_ok = req_legal && priv_ok && !limit_fail && !type_fail;
    wire logic do_load = req_valid && load_ok;
    wire logic do_fault = req_valid && !load_ok;

    // current level changes only on a control transfer
    always_ff @(posedge clk)
    begin
        if (rst)
            current_priv_level <= LVL_RESET;
        else if (xfer_valid)
            current_priv_level <= xfer_level;
    end

    // result of the load, one pulse per request
    always_ff @(posedge clk)
    begin
        if (rst)
            result <= SPC_IDLE;
        else if (do_load)
            result <= SPC_LOADED;
        else if (do_fault)
            result <= SPC_FAULTED;
        else
            result <= SPC_IDLE;
    end

    // answer pulses decoded from the result
    always_comb
    begin
        case (result)
            SPC_LOADED:
            begin
                load_done = 1'b1;
                protection_fault = 1'b0;
            end
            SPC_FAULTED:
            begin
                load_done = 1'b0;
                protection_fault = 1'b1;
            end
            default:
            begin
                load_done = 1'b0;
                protection_fault = 1'b0;
            end
        endcase
    end

    // visible selectors and hidden parts, written only on a permitted load
    genvar g;
    generate
        for (g = 0; g < NUM_SEG; g++)
        begin : g_seg
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    seg_sel[g] <= '0;
                    seg_desc[g] <= '0;
                end
                else if (do_load && (req_target == 3'(g)))
                begin
                    seg_sel[g] <= req_selector;
                    seg_desc[g] <= req_descriptor;
                end
            end
        end
    endgenerate

    // bookkeeping of the last request and the last fault
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            last_tgt <= '0;
            fault_tgt <= '0;
            last_sel <= '0;
        end
        else if (req_valid)
        begin
            last_tgt <= req_target;
            if (do_fault)
            begin
                fault_tgt <= req_target;
                last_sel <= req_selector;
            end
        end
    end

    // axi write channel state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_ctrl = wr_fire && (aw_addr == REG_CTRL);
    wire logic wr_cnt = wr_fire && (aw_addr == REG_FAULT_CNT) && (w_strb != 4'h0);
    wire logic cnt_inc = ctrl[CTRL_CNT_EN] && (result == SPC_FAULTED);

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    // write address and data latches, response after both
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control register with byte lanes
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl <= CTRL_RESET;
        else if (wr_ctrl)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (w_strb[b])
                    ctrl[8*b +: 8] <= w_data[8*b +: 8];
            end
        end
    end

    // fault counter, a fault in the clearing cycle still counts
    always_ff @(posedge clk)
    begin
        if (rst)
            fault_cnt <= CNT_RESET;
        else if (cnt_inc)
            fault_cnt <= wr_cnt ? 32'h0000_0001 : fault_cnt + 32'h0000_0001;
        else if (wr_cnt)
            fault_cnt <= CNT_RESET;
    end

    // read data selection
    wire logic [31:0] status_word = {25'h0, fault_tgt, code64, long_mode, current_priv_level};
    wire logic [31:0] rd_word = (s_axi_araddr == REG_CTRL) ? ctrl :
                                (s_axi_araddr == REG_STATUS) ? status_word :
                                (s_axi_araddr == REG_FAULT_CNT) ? fault_cnt :
                                (s_axi_araddr == REG_LAST_SEL) ? {16'h0, last_sel} : 32'h0;

    assign s_axi_arready = !s_axi_rvalid;

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_level_range: assert property (
        (current_priv_level >= LVL_MOST) && (current_priv_level <= LVL_LEAST) &&
        (eff_level >= requestor_priv_level) && (eff_level >= current_priv_level))
        else $error("effective level below an input level");

    a_level_only_xfer: assert property (
        !xfer_valid |=> $stable(current_priv_level))
        else $error("current level changed without a transfer");

    a_data_pass: assert property (
        req_valid && tgt_data && !limit_fail && !type_fail &&
        (eff_level <= descriptor_priv_level)
        |=> load_done && !protection_fault && (seg_sel[last_tgt] == $past(req_selector)))
        else $error("permitted data load not written");

    a_data_fail: assert property (
        req_valid && tgt_data &&
        ((requestor_priv_level > descriptor_priv_level) || (current_priv_level > descriptor_priv_level))
        |=> protection_fault && !load_done)
        else $error("data load with low privilege not faulted");

    a_stack_req: assert property (
        req_valid && tgt_stack && (requestor_priv_level != current_priv_level)
        |=> protection_fault ##0 $stable(seg_sel[TGT_STACK]))
        else $error("stack load with unequal requestor level taken");

    a_stack_desc: assert property (
        req_valid && tgt_stack && (descriptor_priv_level != current_priv_level)
        |=> protection_fault ##0 $stable(seg_desc[TGT_STACK]))
        else $error("stack load with unequal descriptor level taken");

    a_hidden_copy: assert property (
        load_done |-> seg_desc[last_tgt] == $past(req_descriptor))
        else $error("hidden part not copied on load");

    a_fault_keeps: assert property (
        protection_fault |-> !load_done && $stable(seg_sel) && $stable(seg_desc))
        else $error("faulted load changed a segment register");

    a_mode64_limit: assert property (
        req_valid && mode64 && !req_sys_table && tgt_data &&
        (eff_level <= descriptor_priv_level) |=> load_done && !protection_fault)
        else $error("limit check applied in 64-bit mode");

    a_compat_limit: assert property (
        req_valid && long_mode && !code64 && req_limit_viol |=> protection_fault)
        else $error("limit check skipped in compatibility mode");

endmodule : spc_checker

`default_nettype wire

/* File: spc_exec_model.sv */
// partner model: execution logic issuing segment loads and level changes
`timescale 1ns/1ps
`default_nettype none

module spc_exec_model
    import spc_pkg::*;
(
    input wire logic clk,
    output logic long_mode,
    output logic code64,
    output logic xfer_valid,
    output logic [1:0] xfer_level,
    output logic req_valid,
    output logic [2:0] req_target,
    output logic [15:0] req_selector,
    output logic [63:0] req_descriptor,
    output logic [2:0] req_flags
);
    // idle values at time zero
    initial
    begin
        {long_mode, code64, xfer_valid, req_valid} = 4'h0;
        xfer_level = 2'h0;
        req_target = 3'h0;
        req_selector = 16'h0000;
        req_descriptor = 64'h0;
        req_flags = 3'h0;
    end

    // mode levels change right after an edge
    task automatic set_mode(input logic lm, input logic c64);
        @(posedge clk);
        long_mode <= lm;
        code64 <= c64;
    endtask : set_mode

    // one-cycle transfer pulse, level scrambled outside it
    task automatic set_level(input logic [1:0] lvl);
        @(posedge clk);
        xfer_valid <= 1'b1;
        xfer_level <= lvl;
        @(posedge clk);
        xfer_valid <= 1'b0;
        xfer_level <= ~lvl;
    endtask : set_level

    // one-cycle load pulse; selector and descriptor inverted once it is taken
    task automatic load(input logic [2:0] t, input logic [15:0] s, input logic [63:0] d, input logic [2:0] f);
        @(posedge clk);
        req_valid <= 1'b1;
        req_target <= t;
        req_selector <= s;
        req_descriptor <= d;
        req_flags <= f;
        @(posedge clk);
        req_valid <= 1'b0;
        req_selector <= ~s;
        req_descriptor <= ~d;
    endtask : load
endmodule : spc_exec_model
`default_nettype wire

/* File: spc_pkg.sv */
// package of constants and types for the segment privilege checker
`default_nettype none
package spc_pkg;

    // privilege level width and reset value
    localparam int LVL_W = 2;
    localparam logic [1:0] LVL_MOST = 2'h0;
    localparam logic [1:0] LVL_LEAST = 2'h3;
    localparam logic [1:0] LVL_RESET = 2'h0;

    // selector and descriptor layout
    localparam int SEL_W = 16;
    localparam int DESC_W = 64;
    localparam int SEL_LVL_LSB = 0;
    localparam int DESC_LVL_LSB = 45;

    // segment register targets
    localparam int NUM_SEG = 5;
    localparam logic [2:0] TGT_DATA_PRIMARY = 3'h0;
    localparam logic [2:0] TGT_DATA_EXTRA = 3'h1;
    localparam logic [2:0] TGT_DATA_THIRD = 3'h2;
    localparam logic [2:0] TGT_DATA_FOURTH = 3'h3;
    localparam logic [2:0] TGT_STACK = 3'h4;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAULT_CNT = 8'h08;
    localparam logic [7:0] REG_LAST_SEL = 8'h0C;

    // field positions and reset values
    localparam int CTRL_CNT_EN = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_LVL_LSB = 0;
    localparam int STAT_LONG = 2;
    localparam int STAT_CODE64 = 3;
    localparam int STAT_TGT_LSB = 4;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // answer of one load request
    typedef enum logic [1:0] {
        SPC_IDLE,
        SPC_LOADED,
        SPC_FAULTED
    } spc_result_t;

endpackage : spc_pkg

`default_nettype wire

/* File: tb.sv */
// self-checking bench for the segment privilege checker
`timescale 1ns/1ps
`default_nettype none

module tb;
    import spc_pkg::*;
    logic clk, rst, long_mode, code64, xfer_valid, req_valid, load_done, protection_fault;
    logic [1:0] xfer_level, bresp, rresp;
    logic [2:0] req_target, req_flags;
    logic [15:0] req_selector, last_bad;
    logic [63:0] req_descriptor;
    logic [4:0][15:0] seg_sel;
    logic [4:0][63:0] seg_desc;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] exp_sel [5];
    logic [63:0] exp_desc [5];
    logic [1:0] rs;
    int err_total, cmp_count, nfault;

    spc_exec_model mdl (.clk(clk), .long_mode(long_mode), .code64(code64), .xfer_valid(xfer_valid),
        .xfer_level(xfer_level), .req_valid(req_valid), .req_target(req_target), .req_selector(req_selector),
        .req_descriptor(req_descriptor), .req_flags(req_flags));

    spc_checker DUT (.clk(clk), .rst(rst), .long_mode(long_mode), .code64(code64), .xfer_valid(xfer_valid),
        .xfer_level(xfer_level), .req_valid(req_valid), .req_target(req_target), .req_selector(req_selector),
        .req_descriptor(req_descriptor), .req_limit_viol(req_flags[2]), .req_type_viol(req_flags[1]),
        .req_sys_table(req_flags[0]), .load_done(load_done), .protection_fault(protection_fault),
        .seg_sel(seg_sel), .seg_desc(seg_desc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // axi write; handshakes judged between edges, acted on after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            rs = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b)
            begin
                bready <= 1'b0;
                break;
            end
        end
        if (b !== 1'b1) err_total++; // write response never came
    endtask : wr

    // axi read into rd_v and rs
    task automatic rd(input logic [7:0] a);
        logic ar, r;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clk);
            ar = arvalid && arready;
            r = rvalid;
            rd_v = rdata;
            rs = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (r)
            begin
                rready <= 1'b0;
                break;
            end
        end
        if (r !== 1'b1) err_total++; // read data never came
    endtask : rd

    // selector with requestor level in bits 1:0, descriptor level in bits 46:45
    function automatic logic [15:0] mk_sel(input logic [1:0] q, input int k);
        return {4'hA, 4'(k), 6'h15, q};
    endfunction : mk_sel

    function automatic logic [63:0] mk_desc(input logic [1:0] l, input int k);
        return {17'h15A3C, l, 13'h0B5E, 32'(k)};
    endfunction : mk_desc

    // one load judged one cycle after it is taken
    task automatic do_load(input logic [2:0] t, input logic [15:0] s, input logic [63:0] d,
        input logic [2:0] f, input logic bad);
        mdl.load(t, s, d, f);
        #1;
        chk("load_done", 64'(load_done), 64'(!bad));
        chk("fault", 64'(protection_fault), 64'(bad));
        if (bad)
        begin
            nfault++;
            last_bad = s;
        end
        else if (t < 3'h5)
        begin
            exp_sel[t] = s;
            exp_desc[t] = d;
        end
        if (t < 3'h5)
        begin
            chk("seg_sel", 64'(seg_sel[t]), 64'(exp_sel[t]));
            chk("seg_desc", seg_desc[t], exp_desc[t]);
        end
    endtask : do_load

    // data loads over every current, requestor and descriptor level
    task automatic test_data;
        logic [1:0] e;
        for (int c = 0; c < 4; c++)
        begin
            mdl.set_level(2'(c));
            for (int k = 0; k < 16; k++)
            begin
                e = (k[1:0] > 2'(c)) ? k[1:0] : 2'(c);
                do_load(3'(k % 4), mk_sel(k[1:0], k), mk_desc(k[3:2], k), 3'h0, e > k[3:2]);
            end
        end
    endtask : test_data

    // stack loads need both levels equal to the current one
    task automatic test_stack;
        for (int c = 0; c < 4; c++)
        begin
            mdl.set_level(2'(c));
            for (int k = 0; k < 16; k++)
                do_load(TGT_STACK, mk_sel(k[1:0], k), mk_desc(k[3:2], k), 3'h0,
                    k[1:0] != 2'(c) || k[3:2] != 2'(c));
        end
    endtask : test_stack

    // limit and type relaxations per mode: {long, code64, limit, type, sys, fault}
    task automatic test_modes;
        logic [5:0] tv [7] = '{6'b001001, 6'b101001, 6'b100101, 6'b111000, 6'b111011, 6'b110110, 6'b100000};
        mdl.set_level(2'h0);
        for (int i = 0; i < 7; i++)
        begin
            mdl.set_mode(tv[i][5], tv[i][4]);
            do_load(TGT_DATA_PRIMARY, mk_sel(2'h0, i), mk_desc(2'h0, i), tv[i][3:1], tv[i][0]);
            rd(REG_STATUS);
            chk("status_long", 64'(rd_v[STAT_LONG]), 64'(tv[i][5]));
            chk("status_code64", 64'(rd_v[STAT_CODE64]), 64'(tv[i][4]));
        end
    endtask : test_modes

    // illegal targets are refused
    task automatic test_bad_target;
        for (int t = 5; t < 8; t++)
            do_load(3'(t), mk_sel(2'h0, t), mk_desc(2'h0, t), 3'h0, 1'b1);
    endtask : test_bad_target

    // register map, fault count, level readback, unmapped access
    task automatic test_regs;
        rd(REG_CTRL);
        chk("ctrl", 64'(rd_v), 64'(CTRL_RESET));
        rd(8'h10);
        chk("unmapped", 64'({rs, rd_v}), 64'({RESP_SLVERR, 32'h0}));
        test_data();
        test_stack();
        test_modes();
        test_bad_target();
        rd(REG_FAULT_CNT);
        chk("fault_cnt", 64'(rd_v), 64'(nfault));
        rd(REG_LAST_SEL);
        chk("last_sel", 64'(rd_v[15:0]), 64'(last_bad));
        mdl.set_level(2'h2);
        rd(REG_STATUS);
        chk("level", 64'(rd_v[1:0]), 64'h2);
        wr(REG_FAULT_CNT, 32'h0);
        chk("bresp", 64'(rs), 64'(RESP_OKAY));
        wr(REG_CTRL, 32'h0);
        rd(REG_CTRL);
        chk("ctrl_off", 64'(rd_v), 64'h0);
        wr(8'h10, 32'h0);
        chk("bresp_unmapped", 64'(rs), 64'(RESP_SLVERR));
        do_load(TGT_STACK, mk_sel(2'h3, 9), mk_desc(2'h2, 9), 3'h0, 1'b1);
        rd(REG_FAULT_CNT);
        chk("fault_cnt_off", 64'(rd_v), 64'h0);
    endtask : test_regs

    // verdict and end of run
    task automatic test_done;
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // watchdog
    initial
    begin
        #40000;
        err_total++;
        test_done();
    end

    // reset then scenarios
    initial
    begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        exp_sel = '{default: '0};
        exp_desc = '{default: '0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_done();
    end
endmodule : tb
`default_nettype wire
